// *** include/msg_ctrl_pkg.sv ***
package msg_ctrl_pkg;
  localparam int DATA_W = 16;
  // register selects {A2,A1,A0}
  localparam logic [2:0] SEL_IRQ_MASK = 3'h0;
  localparam logic [2:0] SEL_CONFIG = 3'h1;
  localparam logic [2:0] SEL_UNUSED = 3'h2;
  localparam logic [2:0] SEL_START_RESET = 3'h3;
  localparam int SEL_EXT_BIT = 2;
  // configuration fields
  localparam int CFG_AREA_BIT = 13;
  localparam int CFG_STOP_ERR_BIT = 12;
  localparam int CFG_RT_BIT = 15;
  localparam int CFG_MON_BIT = 14;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  // interrupt mask bits
  localparam int IRQ_EOM_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_BLOCK_BIT = 2;
  // start/reset command bits
  localparam int CMD_START_BIT = 1;
  localparam int CMD_RESET_BIT = 0;
  // block status word bits
  localparam int BSW_DONE_BIT = 15;
  localparam int BSW_BEGUN_BIT = 14;
  localparam int BSW_CHAN_BIT = 13;
  localparam int BSW_ERR_BIT = 12;
  localparam int BSW_STATSET_BIT = 11;
  localparam int BSW_FORMAT_BIT = 10;
  localparam int BSW_TIMEOUT_BIT = 9;
  localparam int BSW_LOOP_BIT = 8;
  // descriptor stack geometry
  localparam int STACK_ENTRIES = 64;
  localparam int ENTRY_WORDS = 4;
  localparam logic [7:0] ENTRY_STEP = 8'h04;
  localparam logic [15:0] MSG_COUNT_LAST = 16'hffff;
  // time-out
  localparam int CLK_MHZ = 25;
  localparam int TIMEOUT_US = 14;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_BUSY = 2'b01,
    MS_WAIT = 2'b10
  } msgState_t;
endpackage : msg_ctrl_pkg

// *** logic/dual_area_message_control.sv ***
// Function
// - config bit 13 selects current area: 0 is A, 1 is B
// - area change waits until any message in progress has finished
// - descriptor stack holds 64 entries of four words each
// - time tag written at message begin and again at message end
// - done bit set at message completion regardless of errors
// - begun bit set at message start, cleared at completion
// - channel bit records receiving bus; controller mode follows control word
// - error flag set on any error; causes in bits 8 to 11
// - controller status-set on status flags, message error or address mismatch
// - format error on word violations or, in terminal mode only, wrong transmitter address
// - response timeout after 14 us without answer
// - loop test fail bit set when wrap-around test fails
// - fourth word: data block address (controller) or command word (terminal)
// - stack pointer high byte fixed, low byte wraps without carry
// - terminal finds data block by table on T/R and subaddress, two tables
// - up to four external registers via enable and load strobes
// - 16-bit read/write configuration register
// - interrupt pulsed low in the cycle after the done cycle when masked condition occurs
// - done condition after every transfer in controller or terminal mode
// - error condition on loop, validation, timeout or status set
// - block complete condition in controller mode only, when message count reaches FFFF
// - write-only start/reset; reset aborts and clears config and mask
// - internal decode: mask 000, config 001, unused 010, start/reset 011
`timescale 1ns/1ps
module msg_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic doWr;
  logic doRd;
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  assign outData = mem[rdPtr_q];
  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_q] <= inData;
    end
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (doWr) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRd) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule : msg_fifo

module dual_area_message_control
  import msg_ctrl_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  // host register port
  input wire logic regSelN,
  input wire logic [2:0] hostAddr,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [msg_ctrl_pkg::DATA_W-1:0] hostWrData,
  output logic [msg_ctrl_pkg::DATA_W-1:0] hostRdData,
  output logic externalRegEnableN,
  output logic externalRegLoadN,
  output logic [1:0] externalRegSel,
  input wire logic [msg_ctrl_pkg::DATA_W-1:0] externalRegData,
  // protocol engine events
  input wire logic msgStart,
  input wire logic msgEnd,
  input wire logic rxChannelB,
  input wire logic ctrlWordChannelA,
  input wire logic responseSeen,
  input wire logic [3:0] wordErrors,
  input wire logic statusFlagsSet,
  input wire logic statusMsgError,
  input wire logic statusAddrMismatch,
  input wire logic xmitAddrWrong,
  input wire logic loopFail,
  input wire logic [15:0] timeTag,
  input wire logic [15:0] dataBlockAddr,
  input wire logic [15:0] commandWord,
  input wire logic [15:0] messageCount,
  input wire logic [7:0] stackBaseHigh,
  input wire logic stackLoad,
  input wire logic [7:0] stackLoadLow,
  // outputs toward engine and shared ram
  output logic currentAreaB,
  output logic startPulse,
  output logic abortPulse,
  output logic monitorMode,
  output logic remoteTerminalMode,
  output logic stopOnError,
  output logic [15:0] stackPointer,
  output logic [6:0] lookupIndex,
  output logic intN,
  output logic [15:0] ramWrData,
  output logic [15:0] ramWrAddr,
  output logic ramWrValid,
  input wire logic ramWrReady,
  output logic engineStall
);
  import msg_ctrl_pkg::*;
  logic rstMeta_q;
  logic rst_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rst_q <= rstMeta_q;
    end
  end
  function automatic logic selHit(input logic [2:0] a, input logic [2:0] s);
    return a == s;
  endfunction : selHit
  logic [15:0] config_q;
  logic [15:0] mask_q;
  logic areaB_q;
  logic cmdWr;
  logic softReset;
  msgState_t state_q;
  logic [15:0] bsw_q;
  logic [7:0] spLow_q;
  logic [8:0] toCnt_q;
  logic [15:0] tagWord;
  logic anyErr;
  logic pushValid;
  logic [15:0] pushData;
  logic pushReady;
  logic [1:0] pushSlot;
  assign cmdWr = !regSelN && hostWr && selHit(hostAddr, SEL_START_RESET);
  assign softReset = cmdWr && hostWrData[CMD_RESET_BIT];
  assign startPulse = cmdWr && hostWrData[CMD_START_BIT];
  assign abortPulse = softReset;
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      config_q <= CFG_RESET;
      mask_q <= MASK_RESET;
    end else if (softReset) begin
      config_q <= CFG_RESET;
      mask_q <= MASK_RESET;
    end else if (!regSelN && hostWr) begin
      if (selHit(hostAddr, SEL_CONFIG)) begin
        config_q <= hostWrData;
      end
      if (selHit(hostAddr, SEL_IRQ_MASK)) begin
        mask_q <= hostWrData;
      end
    end
  end
  // read data registered; unused and start/reset read as zero
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      hostRdData <= '0;
    end else if (!regSelN && hostRd) begin
      if (hostAddr[SEL_EXT_BIT]) begin
        hostRdData <= externalRegData;
      end else if (selHit(hostAddr, SEL_CONFIG)) begin
        hostRdData <= config_q;
      end else if (selHit(hostAddr, SEL_IRQ_MASK)) begin
        hostRdData <= mask_q;
      end else begin
        hostRdData <= '0;
      end
    end
  end
  assign externalRegEnableN = !(!regSelN && hostRd && hostAddr[SEL_EXT_BIT]);
  assign externalRegLoadN = !(!regSelN && hostWr && hostAddr[SEL_EXT_BIT]);
  assign externalRegSel = hostAddr[1:0];
  assign monitorMode = config_q[CFG_MON_BIT];
  assign remoteTerminalMode = config_q[CFG_RT_BIT];
  assign stopOnError = config_q[CFG_STOP_ERR_BIT];
  // swap only while no message is active; request held in config bit
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      areaB_q <= 1'b0;
    end else if (softReset) begin
      areaB_q <= 1'b0;
    end else if (state_q == MS_IDLE && !msgStart) begin
      areaB_q <= config_q[CFG_AREA_BIT];
    end
  end
  assign currentAreaB = areaB_q;
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      state_q <= MS_IDLE;
    end else if (softReset) begin
      state_q <= MS_IDLE;
    end else begin
      case (state_q)
        MS_IDLE: begin
          if (msgStart) begin
            state_q <= MS_BUSY;
          end
        end
        MS_BUSY: begin
          if (msgEnd) begin
            state_q <= MS_WAIT;
          end
        end
        MS_WAIT: begin
          if (pushSlot == 2'd3 && pushReady) begin
            state_q <= MS_IDLE;
          end
        end
        default: state_q <= MS_IDLE;
      endcase
    end
  end
  // response timer, counts while busy without a response
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      toCnt_q <= '0;
    end else if (state_q != MS_BUSY || responseSeen) begin
      toCnt_q <= '0;
    end else if (toCnt_q != 9'(TIMEOUT_CYCLES)) begin
      toCnt_q <= toCnt_q + 9'd1;
    end
  end
  assign anyErr = |bsw_q[BSW_STATSET_BIT:BSW_LOOP_BIT];
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      bsw_q <= '0;
    end else if (softReset) begin
      bsw_q <= '0;
    end else if (state_q == MS_IDLE && msgStart) begin
      bsw_q <= '0;
      bsw_q[BSW_BEGUN_BIT] <= 1'b1;
    end else if (state_q == MS_BUSY) begin
      if (!remoteTerminalMode) begin
        bsw_q[BSW_STATSET_BIT] <= bsw_q[BSW_STATSET_BIT] | statusFlagsSet | statusMsgError
          | statusAddrMismatch;
        bsw_q[BSW_CHAN_BIT] <= !ctrlWordChannelA;
      end else begin
        bsw_q[BSW_CHAN_BIT] <= rxChannelB;
      end
      bsw_q[BSW_FORMAT_BIT] <= bsw_q[BSW_FORMAT_BIT] | (|wordErrors)
        | (remoteTerminalMode && xmitAddrWrong);
      if (toCnt_q == 9'(TIMEOUT_CYCLES)) begin
        bsw_q[BSW_TIMEOUT_BIT] <= 1'b1;
      end
      bsw_q[BSW_LOOP_BIT] <= bsw_q[BSW_LOOP_BIT] | loopFail;
      if (msgEnd) begin
        bsw_q[BSW_DONE_BIT] <= 1'b1;
        bsw_q[BSW_BEGUN_BIT] <= 1'b0;
      end
    end else if (state_q == MS_WAIT) begin
      bsw_q[BSW_ERR_BIT] <= anyErr;
    end
  end
  // stack pointer: the low byte counts, the high byte never takes a carry
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      spLow_q <= '0;
    end else if (stackLoad) begin
      spLow_q <= stackLoadLow;
    end else if (state_q == MS_WAIT && pushSlot == 2'd3 && pushReady) begin
      spLow_q <= spLow_q + ENTRY_STEP;
    end
  end
  assign stackPointer = {stackBaseHigh, spLow_q};
  // lookup index {T/R, subaddress}, area picks one of the two tables
  assign lookupIndex = {areaB_q, commandWord[10], commandWord[9:5]};
  // descriptor writes: tag at start, then bsw/tag/word4 at end, through fifo
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      pushSlot <= 2'd0;
    end else if (softReset) begin
      pushSlot <= 2'd0;
    end else if (state_q == MS_WAIT && pushReady) begin
      pushSlot <= pushSlot + 2'd1;
    end
  end
  assign tagWord = timeTag;
  always_comb begin
    pushValid = 1'b0;
    pushData = tagWord;
    if (state_q == MS_IDLE && msgStart) begin
      pushValid = 1'b1;
    end else if (state_q == MS_WAIT) begin
      pushValid = 1'b1;
      case (pushSlot)
        2'd1: pushData = {bsw_q[15:13], anyErr, bsw_q[11:0]};
        2'd2: pushData = tagWord;
        2'd3: pushData = remoteTerminalMode ? commandWord : dataBlockAddr;
        default: pushData = tagWord;
      endcase
    end
  end
  // stall the engine when the buffer cannot accept a descriptor word
  assign engineStall = !pushReady;
  logic [31:0] fifoOut;
  // word offset added in the low byte only, so an entry never carries into the high byte
  msg_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rstN(rst_q),
    .inData({stackBaseHigh, spLow_q + (pushSlot == 2'd1 ? 8'h00 : (pushSlot == 2'd3 ? 8'h03 : 8'h01)), pushData}),
    .inValid(pushValid && state_q != MS_WAIT || (state_q == MS_WAIT && pushSlot != 2'd0)),
    .inReady(pushReady),
    .outData(fifoOut),
    .outValid(ramWrValid),
    .outReady(ramWrReady)
  );
  assign ramWrAddr = fifoOut[31:16];
  assign ramWrData = fifoOut[15:0];
  // interrupt pulse in the cycle after the done cycle
  logic doneCycle;
  logic irqHit;
  assign doneCycle = state_q == MS_BUSY && msgEnd && !monitorMode;
  assign irqHit = mask_q[IRQ_EOM_BIT]
    || (mask_q[IRQ_ERR_BIT] && (anyErr || |wordErrors || loopFail))
    || (mask_q[IRQ_BLOCK_BIT] && !remoteTerminalMode && messageCount == MSG_COUNT_LAST);
  always_ff @(posedge core_clk or negedge rst_q) begin
    if (!rst_q) begin
      intN <= 1'b1;
    end else begin
      intN <= !(doneCycle && irqHit);
    end
  end
  AST_INT_PULSE: assert property (@(posedge core_clk) disable iff (!rst_q)
    (doneCycle && mask_q[IRQ_EOM_BIT]) |=> !intN ##1 intN) else $error("int pulse missing");
  AST_DONE_SET: assert property (@(posedge core_clk) disable iff (!rst_q)
    (state_q == MS_BUSY && msgEnd && !softReset) |=> bsw_q[BSW_DONE_BIT] && !bsw_q[BSW_BEGUN_BIT])
    else $error("done bit not set");
  AST_BEGUN_SET: assert property (@(posedge core_clk) disable iff (!rst_q)
    (state_q == MS_IDLE && msgStart && !softReset) |=> bsw_q[BSW_BEGUN_BIT]) else $error("begun bit");
  AST_NO_SWAP_BUSY: assert property (@(posedge core_clk) disable iff (!rst_q)
    (state_q != MS_IDLE && !softReset) |=> $stable(areaB_q)) else $error("swap mid message");
  AST_SP_WRAP: assert property (@(posedge core_clk) disable iff (!rst_q)
    (state_q == MS_WAIT && pushSlot == 2'd3 && pushReady && !stackLoad)
    |=> spLow_q == $past(spLow_q) + ENTRY_STEP) else $error("stack step");
  AST_RESET_CLEARS: assert property (@(posedge core_clk) disable iff (!rst_q)
    softReset |=> config_q == '0 && mask_q == '0) else $error("reset clear");
  AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (!rst_q)
    (state_q == MS_BUSY && toCnt_q == 9'(TIMEOUT_CYCLES) && !softReset) |=> bsw_q[BSW_TIMEOUT_BIT])
    else $error("timeout bit");
  AST_EXT_STROBE: assert property (@(posedge core_clk) disable iff (!rst_q)
    (!regSelN && hostWr && hostAddr[SEL_EXT_BIT]) |-> !externalRegLoadN && externalRegEnableN)
    else $error("ext load strobe");
endmodule : dual_area_message_control

// *** test/ram_sink_model.sv ***
`timescale 1ns/1ps
module ram_sink_model (
  input wire logic clk,
  input wire logic [15:0] ramWrAddr,
  input wire logic [15:0] ramWrData,
  input wire logic ramWrValid,
  input wire logic stall,
  input wire logic slow,
  output logic ramWrReady
);
  logic [15:0] mem [logic [15:0]];
  logic phase;
  initial begin
    phase = 1'b0;
    ramWrReady = 1'b0;
  end
  // ready moves only after a falling edge, so the fifo sees it settled at the rising edge
  always @(negedge clk) begin
    phase <= ~phase;
    ramWrReady <= ~stall & ~(slow & phase);
  end
  always @(posedge clk) begin
    if (ramWrValid === 1'b1 && ramWrReady === 1'b1) mem[ramWrAddr] = ramWrData;
  end
endmodule : ram_sink_model

// *** test/tb_dual_area_message_control.sv ***
`timescale 1ns/1ps
module tb_dual_area_message_control;
  import msg_ctrl_pkg::*;
  localparam int TO = 20;
  logic core_clk = 1'b0, nrst = 1'b0, regSelN = 1'b1, hostWr = 1'b0, hostRd = 1'b0;
  logic [2:0] hostAddr = 3'h0;
  logic [15:0] hostWrData = 16'h0000, externalRegData = 16'h5a3c, hostRdData;
  logic externalRegEnableN, externalRegLoadN, currentAreaB, startPulse, abortPulse;
  logic monitorMode, remoteTerminalMode, stopOnError, intN, ramWrValid, ramWrReady, engineStall;
  logic [1:0] externalRegSel;
  logic [6:0] lookupIndex;
  logic [15:0] stackPointer, ramWrData, ramWrAddr;
  logic msgStart = 1'b0, msgEnd = 1'b0, rxChannelB = 1'b0, ctrlWordChannelA = 1'b1, responseSeen = 1'b1;
  logic statusFlagsSet = 1'b0, statusMsgError = 1'b0, statusAddrMismatch = 1'b0, xmitAddrWrong = 1'b0;
  logic loopFail = 1'b0, stackLoad = 1'b0, stall = 1'b0, slow = 1'b0;
  logic [3:0] wordErrors = 4'h0;
  logic [15:0] timeTag = 16'h0000, dataBlockAddr = 16'h0abc, commandWord = 16'h0c45, messageCount = 16'h0000;
  logic [7:0] stackBaseHigh = 8'h12, stackLoadLow = 8'h00, spLow = 8'h00, lastLow;
  logic [2:0] pulses;
  logic [15:0] rdv;
  int bad_count = 0, num_checks = 0, intLows = 0, cycles = 0, i0;

  dual_area_message_control #(.TIMEOUT_CYCLES(TO)) dut (.core_clk, .nrst, .regSelN, .hostAddr, .hostWr,
    .hostRd, .hostWrData, .hostRdData, .externalRegEnableN, .externalRegLoadN, .externalRegSel,
    .externalRegData, .msgStart, .msgEnd, .rxChannelB, .ctrlWordChannelA, .responseSeen, .wordErrors,
    .statusFlagsSet, .statusMsgError, .statusAddrMismatch, .xmitAddrWrong, .loopFail, .timeTag,
    .dataBlockAddr, .commandWord, .messageCount, .stackBaseHigh, .stackLoad, .stackLoadLow, .currentAreaB,
    .startPulse, .abortPulse, .monitorMode, .remoteTerminalMode, .stopOnError, .stackPointer, .lookupIndex,
    .intN, .ramWrData, .ramWrAddr, .ramWrValid, .ramWrReady, .engineStall);
  ram_sink_model ram (.clk(core_clk), .ramWrAddr, .ramWrData, .ramWrValid, .stall, .slow, .ramWrReady);

  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (intN === 1'b0) intLows++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge core_clk);
    regSelN = 1'b0;
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'b1;
    #1 pulses = {startPulse, abortPulse, externalRegLoadN};
    @(negedge core_clk);
    hostWr = 1'b0;
    regSelN = 1'b1;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(negedge core_clk);
    regSelN = 1'b0;
    hostAddr = a;
    hostRd = 1'b1;
    #1 if (a[2]) chk("ext enable", {externalRegEnableN, externalRegSel}, {1'b0, a[1:0]});
    @(negedge core_clk);
    hostRd = 1'b0;
    regSelN = 1'b1;
    rdv = hostRdData;
  endtask : rd

  task automatic run_msg(input int busy);
    @(negedge core_clk) msgStart = 1'b1;
    timeTag = 16'h1111;
    @(negedge core_clk) msgStart = 1'b0;
    repeat (busy) @(negedge core_clk);
    timeTag = 16'h2222;
    msgEnd = 1'b1;
    @(negedge core_clk) msgEnd = 1'b0;
  endtask : run_msg

  // waits out the descriptor pushes, then checks the pointer moved one entry
  task automatic drain();
    int n;
    n = 0;
    repeat (6) @(negedge core_clk);
    while (ramWrValid !== 1'b0 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk("drained", ramWrValid, 0);
    lastLow = spLow;
    spLow = spLow + ENTRY_STEP;
    chk("pointer", stackPointer, {stackBaseHigh, spLow});
  endtask : drain

  task automatic load_sp(input logic [7:0] lo);
    @(negedge core_clk) stackLoad = 1'b1;
    stackLoadLow = lo;
    @(negedge core_clk) stackLoad = 1'b0;
    spLow = lo;
  endtask : load_sp

  function automatic logic [15:0] ent(input int w);
    return ram.mem[{stackBaseHigh, lastLow + 8'(w)}];
  endfunction : ent

  task automatic t_regs();
    rd(SEL_CONFIG);
    chk("cfg reset", rdv, CFG_RESET);
    wr(SEL_CONFIG, 16'h1005);
    rd(SEL_CONFIG);
    chk("cfg rw", rdv, 16'h1005);
    chk("stop on error", stopOnError, 1);
    wr(SEL_IRQ_MASK, 16'h00f8);
    rd(SEL_IRQ_MASK);
    chk("mask flags", rdv, 16'h00f8);
    wr(SEL_UNUSED, 16'hffff);
    rd(SEL_UNUSED);
    chk("unused", rdv, 0);
    rd(SEL_START_RESET);
    chk("cmd wo", rdv, 0);
    rd(3'h6);
    chk("ext read", rdv, 16'h5a3c);
    wr(3'h5, 16'h0001);
    chk("ext load", pulses[0], 0);
    wr(SEL_CONFIG, 16'h0000);
  endtask : t_regs

  task automatic t_bc_msg();
    wr(SEL_IRQ_MASK, 16'h0001);
    load_sp(8'h00);
    slow = 1'b1;
    i0 = intLows;
    run_msg(5);
    drain();
    slow = 1'b0;
    chk("bsw", ent(0) & 16'hdf00, 16'h8000);
    chk("tag", ent(1), 16'h2222);
    chk("word4 bc", ent(3), 16'h0abc);
    chk("eom irq", 16'(intLows - i0), 1);
    wr(SEL_IRQ_MASK, 16'h0000);
    i0 = intLows;
    ctrlWordChannelA = 1'b0;
    run_msg(2);
    drain();
    ctrlWordChannelA = 1'b1;
    chk("masked", 16'(intLows - i0), 0);
    chk("chan bc", ent(0) & 16'h2000, 16'h2000);
  endtask : t_bc_msg

  task automatic t_rt();
    wr(SEL_CONFIG, 16'h8000);
    rxChannelB = 1'b1;
    run_msg(3);
    drain();
    chk("rt mode", remoteTerminalMode, 1);
    chk("chan", ent(0) & 16'h2000, 16'h2000);
    chk("word4 rt", ent(3), 16'h0c45);
    chk("lookup", lookupIndex, 7'h22);
    rxChannelB = 1'b0;
    wr(SEL_IRQ_MASK, 16'h0001);
    wr(SEL_CONFIG, 16'h4000);
    i0 = intLows;
    run_msg(2);
    drain();
    chk("monitor mode", monitorMode, 1);
    chk("no eom in monitor", 16'(intLows - i0), 0);
    wr(SEL_IRQ_MASK, 16'h0000);
    wr(SEL_CONFIG, 16'h0000);
  endtask : t_rt

  task automatic err_case(input logic [3:0] we, input logic sf, input logic lf, input logic rs,
                          input logic [15:0] exp);
    wordErrors = we;
    statusFlagsSet = sf;
    loopFail = lf;
    responseSeen = rs;
    i0 = intLows;
    run_msg(rs ? 4 : TO + 10);
    drain();
    chk("err bsw", ent(0) & 16'hdf00, exp);
    chk("err irq", 16'(intLows - i0), 1);
    {wordErrors, statusFlagsSet, loopFail, responseSeen} = 7'h01;
  endtask : err_case

  task automatic t_errors();
    wr(SEL_IRQ_MASK, 16'h0002);
    err_case(4'h1, 0, 0, 1, 16'h9400);
    err_case(4'h0, 1, 0, 1, 16'h9800);
    err_case(4'h0, 0, 1, 1, 16'h9100);
    err_case(4'h0, 0, 0, 0, 16'h9200);
    wr(SEL_IRQ_MASK, 16'h0004);
    messageCount = MSG_COUNT_LAST;
    i0 = intLows;
    run_msg(3);
    drain();
    chk("block irq", 16'(intLows - i0), 1);
    messageCount = 16'h0000;
  endtask : t_errors

  task automatic t_wrap_swap();
    load_sp(8'hfc);
    run_msg(2);
    drain();
    chk("wrap", stackPointer, 16'h1200);
    msgStart = 1'b1;
    timeTag = 16'h3333;
    @(negedge core_clk) msgStart = 1'b0;
    wr(SEL_CONFIG, 16'h2000);
    repeat (3) @(negedge core_clk);
    chk("swap held", currentAreaB, 0);
    chk("start tag", ram.mem[{stackBaseHigh, spLow + 8'h01}], 16'h3333);
    msgEnd = 1'b1;
    @(negedge core_clk) msgEnd = 1'b0;
    drain();
    chk("area b", currentAreaB, 1);
    wr(SEL_CONFIG, 16'h0000);
    repeat (2) @(negedge core_clk);
    chk("area a", currentAreaB, 0);
  endtask : t_wrap_swap

  task automatic t_fifo_reset();
    stall = 1'b1;
    // the engine starts a message only when idle, so each one is let finish its descriptor writes
    for (int k = 0; k < 6 && engineStall !== 1'b1; k++) begin
      run_msg(2);
      repeat (6) @(negedge core_clk);
      if (k > 0) spLow = spLow + ENTRY_STEP;
    end
    chk("fifo full", engineStall, 1);
    chk("head held", ramWrValid, 1);
    stall = 1'b0;
    drain();
    load_sp(8'h00);
    wr(SEL_CONFIG, 16'h1234);
    wr(SEL_IRQ_MASK, 16'h00ff);
    wr(SEL_START_RESET, 16'h0002);
    chk("start", pulses[2], 1);
    wr(SEL_START_RESET, 16'h0001);
    chk("abort", pulses[1], 1);
    rd(SEL_CONFIG);
    chk("cfg cleared", rdv, 0);
    rd(SEL_IRQ_MASK);
    chk("mask cleared", rdv, 0);
  endtask : t_fifo_reset

  initial begin
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    t_regs();
    t_bc_msg();
    t_rt();
    t_errors();
    t_wrap_swap();
    t_fifo_reset();
    report_and_stop();
  end
endmodule : tb_dual_area_message_control
